// ---- hw/capture_edge_detect.sv ----
// Synchroniser and selectable edge detector for the capture pin.
// Assumes the pin may change at any time relative to the bus clock.
`timescale 1ns/1ps
`default_nettype none

module capture_edge_detect (
  input wire logic ref_clk_in,
  input wire logic pin_in,
  input wire logic rising_in,
  output logic edge_out
);

  logic sync_a;
  logic sync_b;
  logic last;

  // Only sync_b and later stages are looked at
  always_ff @(posedge ref_clk_in) begin
    sync_a <= pin_in;
    sync_b <= sync_a;
    last <= sync_b;
  end

  always_ff @(posedge ref_clk_in) begin
    edge_out <= rising_in ? (sync_b & ~last) : (~sync_b & last);
  end

endmodule

`default_nettype wire

// ---- hw/tcc_pkg.sv ----
// Constants, types and register map of the timer capture/compare unit.
// Assumes a single 40 MHz bus clock and an APB master with 32-bit data.
//
// What this block does
// - Compare value is two bytes at 0x16/0x17, read/write, never touched by reset.
// - Counter equal to compare value sets compare flag and loads output level.
// - Writing compare high byte stops matching until the low byte is written.
// - Writing one compare byte leaves the other byte unchanged.
// - Every match loads the pending level, whatever the compare flag holds.
// - Compare evaluated in state one; flag set in the following state three.
// - Compare flag with its enable and CPU mask clear raises timer interrupt.
// - Read-only capture value at 0x14/0x15 latches counter on selected pin edge.
// - Captured value is the counter before the edge plus one.
// - Every valid edge overwrites the capture value, flag set or not.
// - Capture high byte read blocks captures until the low byte is read.
// - Edge between two state-two points sets capture flag in next state three.
// - Capture resolution is one count, four bus clocks.
// - Capture flag with its enable and CPU mask clear raises timer interrupt.
// - Overflow flag with its enable and CPU mask clear raises timer interrupt.
// - Pin select 0 gives port pin to general I/O, 1 to compare output.
// - Edge select 0 falling, 1 rising; reset leaves it unchanged.
// - Pending level appears on pin after next match; reset clears level bits.
// - Compare pin is low during reset, then follows general I/O until pin select is set.
// - Reset touches control register except edge select, output level and counter, not compare or capture values.
// - Counter resets to 0xfffc and advances every four bus clocks.
// - Compare flag clears on status read with flag set, then compare low access.
// - Capture flag clears on status access with flag set, then capture low access.

package tcc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;

  // Register indices; the byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_CONTROL = 8'h12;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 8'h13;
  localparam logic [ADDR_W-1:0] IDX_CAPTURE_HIGH = 8'h14;
  localparam logic [ADDR_W-1:0] IDX_CAPTURE_LOW = 8'h15;
  localparam logic [ADDR_W-1:0] IDX_COMPARE_HIGH = 8'h16;
  localparam logic [ADDR_W-1:0] IDX_COMPARE_LOW = 8'h17;
  localparam logic [ADDR_W-1:0] IDX_COUNTER_HIGH = 8'h18;
  localparam logic [ADDR_W-1:0] IDX_COUNTER_LOW = 8'h19;

  // Control register fields
  localparam int CTL_CAPTURE_IRQ_ENABLE = 7;
  localparam int CTL_COMPARE_IRQ_ENABLE = 6;
  localparam int CTL_OVERFLOW_IRQ_ENABLE = 5;
  localparam int CTL_COMPARE_PIN_SELECT = 2;
  localparam int CTL_CAPTURE_EDGE_SELECT = 1;
  localparam int CTL_PENDING_OUTPUT_LEVEL = 0;

  // Status register fields
  localparam int STS_CAPTURE_FLAG = 7;
  localparam int STS_COMPARE_MATCH_FLAG = 6;
  localparam int STS_OVERFLOW_FLAG = 5;

  localparam logic [CNT_W-1:0] COUNTER_RESET = 16'hfffc;
  localparam logic [CNT_W-1:0] COUNT_ONE = 16'h0001;

  // Four timer states per counter step
  typedef enum logic [1:0] {
    timer_state_zero,
    timer_state_one,
    timer_state_two,
    timer_state_three
  } timer_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [3:0] pstrb;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } apb_rsp_t;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [ADDR_W-1:0] idx);
    byte_addr = {idx[ADDR_W-3:0], 2'b00};
  endfunction

endpackage

// ---- hw/timer_base_counter.sv ----
// Divide-by-four timer state sequencer and 16-bit free-running counter.
// Assumes one bus clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module timer_base_counter (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  output var tcc_pkg::timer_state_t state_out,
  output logic [tcc_pkg::CNT_W-1:0] count_out,
  output logic overflow_out
);
  import tcc_pkg::*;

  timer_state_t next_state;
  wire step = (state_out == timer_state_three);

  always_comb begin
    unique case (state_out)
      timer_state_zero: next_state = timer_state_one;
      timer_state_one: next_state = timer_state_two;
      timer_state_two: next_state = timer_state_three;
      timer_state_three: next_state = timer_state_zero;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_out <= timer_state_zero;
      count_out <= COUNTER_RESET;
      overflow_out <= 1'b0;
    end else begin
      state_out <= next_state;
      if (step) begin
        count_out <= count_out + COUNT_ONE;
      end
      overflow_out <= step && (count_out == '1);
    end
  end

endmodule

`default_nettype wire

// ---- hw/timer_capture_compare_unit.sv ----
// Capture/compare section of a 16-bit free-running timer with an APB slave.
// Assumes an APB master on the same 40 MHz clock and a CPU interrupt mask level.
`timescale 1ns/1ps
`default_nettype none

module timer_capture_compare_unit (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire tcc_pkg::apb_req_t apb_req_in,
  output var tcc_pkg::apb_rsp_t apb_rsp_out,
  input wire logic capture_input_pin_in,
  input wire logic port_c_bit_two_in,
  input wire logic cpu_irq_mask_in,
  output logic port_c_bit_two_out,
  output logic timer_irq_out
);
  import tcc_pkg::*;

  // ----------------------------------------
  // Timer base
  // ----------------------------------------
  timer_state_t state;
  logic [CNT_W-1:0] count;
  logic overflow_pulse;

  timer_base_counter u_base (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .state_out(state),
    .count_out(count),
    .overflow_out(overflow_pulse)
  );

  wire in_state_one = (state == timer_state_one);
  wire in_state_three = (state == timer_state_three);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] compare_value_high;
  logic [7:0] compare_value_low;
  logic [7:0] capture_value_high;
  logic [7:0] capture_value_low;
  logic capture_irq_enable;
  logic compare_irq_enable_alias;
  logic overflow_irq_enable;
  logic compare_pin_select;
  logic capture_edge_select;
  logic pending_output_level;
  logic output_level;
  logic capture_flag;
  logic compare_match_flag;
  logic overflow_flag;
  logic compare_enable;
  logic capture_block;
  logic match_pending;
  logic capture_pending;
  logic arm_capture_clear;
  logic arm_compare_clear;
  logic arm_overflow_clear;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire sel = apb_req_in.psel & apb_req_in.penable;
  wire first_access = sel & ~apb_rsp_out.pready;
  wire done = sel & apb_rsp_out.pready;
  wire wr = done & apb_req_in.pwrite & apb_req_in.pstrb[0];
  wire [7:0] wbyte = apb_req_in.pwdata[7:0];
  wire [ADDR_W-1:0] addr = apb_req_in.paddr;

  wire hit_control = (addr == byte_addr(IDX_CONTROL));
  wire hit_status = (addr == byte_addr(IDX_STATUS));
  wire hit_cap_high = (addr == byte_addr(IDX_CAPTURE_HIGH));
  wire hit_cap_low = (addr == byte_addr(IDX_CAPTURE_LOW));
  wire hit_cmp_high = (addr == byte_addr(IDX_COMPARE_HIGH));
  wire hit_cmp_low = (addr == byte_addr(IDX_COMPARE_LOW));
  wire hit_cnt_high = (addr == byte_addr(IDX_COUNTER_HIGH));
  wire hit_cnt_low = (addr == byte_addr(IDX_COUNTER_LOW));
  wire hit_any = hit_control | hit_status | hit_cap_high | hit_cap_low |
                 hit_cmp_high | hit_cmp_low | hit_cnt_high | hit_cnt_low;

  wire rd = done & ~apb_req_in.pwrite;
  wire wr_control = wr & hit_control;
  wire wr_cmp_high = wr & hit_cmp_high;
  wire wr_cmp_low = wr & hit_cmp_low;
  wire rd_cap_high = rd & hit_cap_high;
  wire acc_status = done & hit_status;
  wire acc_cap_low = done & hit_cap_low;
  wire acc_cmp_low = done & hit_cmp_low;
  wire acc_cnt_low = done & hit_cnt_low;

  wire [7:0] control_byte = {capture_irq_enable, compare_irq_enable_alias,
                             overflow_irq_enable, 2'b00, compare_pin_select,
                             capture_edge_select, pending_output_level};
  wire [7:0] status_byte = {capture_flag, compare_match_flag, overflow_flag, 5'h00};

  wire [7:0] read_byte =
    hit_control ? control_byte :
    hit_status ? status_byte :
    hit_cap_high ? capture_value_high :
    hit_cap_low ? capture_value_low :
    hit_cmp_high ? compare_value_high :
    hit_cmp_low ? compare_value_low :
    hit_cnt_high ? count[15:8] :
    hit_cnt_low ? count[7:0] : 8'h00;

  // One wait state: pready rises in the cycle after the access phase opens
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      apb_rsp_out <= '0;
    end else begin
      apb_rsp_out.pready <= first_access;
      apb_rsp_out.pslverr <= first_access & ~hit_any;
      if (first_access) begin
        apb_rsp_out.prdata <= {24'h000000, read_byte};
      end
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // enables cleared by reset
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      capture_irq_enable <= 1'b0;
      compare_irq_enable_alias <= 1'b0;
      overflow_irq_enable <= 1'b0;
      compare_pin_select <= 1'b0;
    end else if (wr_control) begin
      capture_irq_enable <= wbyte[CTL_CAPTURE_IRQ_ENABLE];
      compare_irq_enable_alias <= wbyte[CTL_COMPARE_IRQ_ENABLE];
      overflow_irq_enable <= wbyte[CTL_OVERFLOW_IRQ_ENABLE];
      compare_pin_select <= wbyte[CTL_COMPARE_PIN_SELECT];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (wr_control) begin
      capture_edge_select <= wbyte[CTL_CAPTURE_EDGE_SELECT];
    end
  end

  // ----------------------------------------
  // Compare
  // ----------------------------------------
  // each byte written alone, no reset
  always_ff @(posedge ref_clk_in) begin
    if (wr_cmp_high) begin
      compare_value_high <= wbyte;
    end
    if (wr_cmp_low) begin
      compare_value_low <= wbyte;
    end
  end

  // high byte write stops matching until low byte
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      compare_enable <= 1'b1;
    end else if (wr_cmp_high) begin
      compare_enable <= 1'b0;
    end else if (wr_cmp_low) begin
      compare_enable <= 1'b1;
    end
  end

  wire match_now = in_state_one & compare_enable &
                   (count == {compare_value_high, compare_value_low});

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      match_pending <= 1'b0;
    end else if (match_now) begin
      match_pending <= 1'b1;
    end else if (in_state_three) begin
      match_pending <= 1'b0;
    end
  end

  wire compare_event = match_pending & in_state_three;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pending_output_level <= 1'b0;
      output_level <= 1'b0;
    end else begin
      if (wr_control) begin
        pending_output_level <= wbyte[CTL_PENDING_OUTPUT_LEVEL];
      end
      if (compare_event) begin
        output_level <= pending_output_level;
      end
    end
  end

  // ----------------------------------------
  // Capture
  // ----------------------------------------
  logic edge_seen;

  capture_edge_detect u_edge (
    .ref_clk_in(ref_clk_in),
    .pin_in(capture_input_pin_in),
    .rising_in(capture_edge_select),
    .edge_out(edge_seen)
  );

  // high byte read blocks transfer until low byte read
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      capture_block <= 1'b0;
    end else if (rd_cap_high) begin
      capture_block <= 1'b1;
    end else if (rd & hit_cap_low) begin
      capture_block <= 1'b0;
    end
  end

  wire capture_take = edge_seen & ~capture_block;

  // latch count plus one, no reset
  always_ff @(posedge ref_clk_in) begin
    if (capture_take) begin
      {capture_value_high, capture_value_low} <= count + COUNT_ONE;
    end
  end

  // flag waits for the next state three
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      capture_pending <= 1'b0;
    end else begin
      capture_pending <= capture_take | (capture_pending & ~in_state_three);
    end
  end

  wire capture_event = capture_pending & in_state_three;

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  // A status access with the flag set arms the clear; the arm lapses on use
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      arm_capture_clear <= 1'b0;
      arm_compare_clear <= 1'b0;
      arm_overflow_clear <= 1'b0;
    end else begin
      if (acc_status) begin
        arm_capture_clear <= capture_flag;
        arm_compare_clear <= compare_match_flag;
        arm_overflow_clear <= overflow_flag;
      end
      if (acc_cap_low) begin
        arm_capture_clear <= 1'b0;
      end
      if (acc_cmp_low) begin
        arm_compare_clear <= 1'b0;
      end
      if (acc_cnt_low) begin
        arm_overflow_clear <= 1'b0;
      end
    end
  end

  // Flags are not reset; a set in the clearing cycle wins
  // capture, compare and overflow flag set and clear sequences
  always_ff @(posedge ref_clk_in) begin
    if (capture_event) begin
      capture_flag <= 1'b1;
    end else if (acc_cap_low & arm_capture_clear) begin
      capture_flag <= 1'b0;
    end
    if (compare_event) begin
      compare_match_flag <= 1'b1;
    end else if (acc_cmp_low & arm_compare_clear) begin
      compare_match_flag <= 1'b0;
    end
    if (overflow_pulse) begin
      overflow_flag <= 1'b1;
    end else if (acc_cnt_low & arm_overflow_clear) begin
      overflow_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // gated by enables and CPU mask
  wire irq_sources = (capture_flag & capture_irq_enable) |
                     (compare_match_flag & compare_irq_enable_alias) |
                     (overflow_flag & overflow_irq_enable);

  wire next_pin = compare_pin_select ? output_level : port_c_bit_two_in;

  // pin low while reset is held
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      port_c_bit_two_out <= 1'b0;
      timer_irq_out <= 1'b0;
    end else begin
      port_c_bit_two_out <= next_pin;
      timer_irq_out <= irq_sources & ~cpu_irq_mask_in;
    end
  end

endmodule

`default_nettype wire

// ---- sim/tcc_chk.sv ----
// Port-level checker for the capture/compare unit.
// Assumes an APB master that holds each request until pready.
`timescale 1ns/1ps
`default_nettype none

module tcc_chk (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire tcc_pkg::apb_req_t apb_req_in,
  input wire tcc_pkg::apb_rsp_t apb_rsp_out,
  input wire logic port_c_bit_two_in,
  input wire logic cpu_irq_mask_in,
  input wire logic port_c_bit_two_out,
  input wire logic timer_irq_out
);
  import tcc_pkg::*;

  logic [7:0] ctl_m;
  logic [1:0] phase;
  logic wr_ctl;
  logic mapped;

  // Mirror of the control register, taken at the completing edge only
  assign wr_ctl = apb_req_in.psel && apb_req_in.penable && apb_rsp_out.pready && apb_req_in.pwrite
    && apb_req_in.pstrb[0] && apb_req_in.paddr == {IDX_CONTROL[5:0], 2'h0};
  assign mapped = apb_req_in.paddr >= 8'h48 && apb_req_in.paddr <= 8'h64 && apb_req_in.paddr[1:0] == 2'h0;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ctl_m <= 8'h00;
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
      if (wr_ctl) begin
        ctl_m <= apb_req_in.pwdata[7:0];
      end
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_wait;
    apb_req_in.psel && apb_req_in.penable && !apb_rsp_out.pready;
  endsequence

  a_reset_pin_low: assert property (disable iff (1'b0) sys_rst_in |=> !port_c_bit_two_out)
    else $error("compare pin not low after reset");
  a_reset_irq_low: assert property (disable iff (1'b0) sys_rst_in |=> !timer_irq_out)
    else $error("interrupt not low after reset");
  a_ready_one_wait: assert property (s_wait |=> apb_rsp_out.pready)
    else $error("pready late");
  a_ready_pulse: assert property (apb_rsp_out.pready |=> !apb_rsp_out.pready)
    else $error("pready longer than one cycle");
  a_error_unmapped: assert property (apb_rsp_out.pready |-> apb_rsp_out.pslverr == !mapped)
    else $error("pslverr does not match address map");
  a_mask_blocks_irq: assert property ($past(cpu_irq_mask_in) |-> !timer_irq_out)
    else $error("interrupt raised while masked");
  a_irq_needs_enable: assert property (timer_irq_out |-> $past(ctl_m[7:5]) != 3'h0)
    else $error("interrupt without any enable");
  a_io_follows_port: assert property (!$past(sys_rst_in) && !$past(ctl_m[2])
    |-> port_c_bit_two_out == $past(port_c_bit_two_in))
    else $error("shared pin not following general io");
  a_pin_moves_aligned: assert property ($changed(port_c_bit_two_out) && $past(ctl_m[2])
    && $past(ctl_m[2], 2) |-> phase == 2'h1)
    else $error("compare pin moved off the timer state");
endmodule

bind timer_capture_compare_unit tcc_chk i_chk (
  .ref_clk_in(ref_clk_in),
  .sys_rst_in(sys_rst_in),
  .apb_req_in(apb_req_in),
  .apb_rsp_out(apb_rsp_out),
  .port_c_bit_two_in(port_c_bit_two_in),
  .cpu_irq_mask_in(cpu_irq_mask_in),
  .port_c_bit_two_out(port_c_bit_two_out),
  .timer_irq_out(timer_irq_out)
);

`default_nettype wire

// ---- sim/tcc_pin_src.sv ----
// Signal source on the timer pins: capture input and general io level.
// Assumes the caller enters drive_cap just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module tcc_pin_src (
  input wire logic ref_clk_in,
  input wire logic toggle_in,
  output logic capture_pin_out,
  output logic io_pin_out
);
  initial begin
    capture_pin_out = 1'b0;
    io_pin_out = 1'b0;
  end

  // Flips every clock so a stale io path cannot pass
  always @(posedge ref_clk_in) begin
    if (toggle_in) begin
      io_pin_out <= !io_pin_out;
    end
  end

  // level held two counts so no edge is lost
  task automatic drive_cap(input logic level);
    @(posedge ref_clk_in);
    capture_pin_out <= level;
    repeat (8) @(posedge ref_clk_in);
  endtask
endmodule

`default_nettype wire

// ---- sim/timer_capture_compare_unit_bench.sv ----
// Self-checking bench for the capture/compare unit over APB.
// Assumes the checker is bound in and the pin source drives the pins.
`timescale 1ns/1ps
`default_nettype none

module timer_capture_compare_unit_bench;
  import tcc_pkg::*;

  logic ref_clk_in, sys_rst_in, cpu_irq_mask_in, cap_pin, io_pin, pin_out, irq;
  apb_req_t req;
  apb_rsp_t rsp;
  int miscompares, compares, cycles;
  logic [7:0] rd;
  logic err;
  logic [15:0] cnt, tgt, cap, cap0;

  timer_capture_compare_unit i_timer_capture_compare_unit (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .apb_req_in(req),
    .apb_rsp_out(rsp),
    .capture_input_pin_in(cap_pin),
    .port_c_bit_two_in(io_pin),
    .cpu_irq_mask_in(cpu_irq_mask_in),
    .port_c_bit_two_out(pin_out),
    .timer_irq_out(irq)
  );

  tcc_pin_src i_tcc_pin_src (
    .ref_clk_in(ref_clk_in),
    .toggle_in(1'b1),
    .capture_pin_out(cap_pin),
    .io_pin_out(io_pin)
  );

  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = !ref_clk_in;
  end

  // ----
  // Tasks
  // ----
  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares = miscompares + 1;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Idle cycle at the end keeps psel from being driven twice in one step
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] wdata);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: {24'h000000, wdata}, pstrb: 4'hf};
    @(posedge ref_clk_in);
    req.penable <= 1'b1;
    do @(posedge ref_clk_in); while (rsp.pready !== 1'b1);
    rd = rsp.prdata[7:0];
    err = rsp.pslverr;
    req <= '0;
    @(posedge ref_clk_in);
  endtask

  task automatic rdr(input logic [7:0] addr);
    apb(1'b0, addr, 8'h00);
  endtask

  // High byte read twice: a low byte near 0xff was read before a carry
  task automatic read_cnt();
    logic [7:0] hi;
    rdr(8'h60);
    hi = rd;
    rdr(8'h64);
    cnt[7:0] = rd;
    rdr(8'h60);
    cnt[15:8] = cnt[7] ? hi : rd;
  endtask

  task automatic read_cap();
    rdr(8'h50);
    cap[15:8] = rd;
    rdr(8'h54);
    cap[7:0] = rd;
  endtask

  task automatic wait_pin(input logic v, input int lim);
    repeat (lim) begin
      if (pin_out === v) break;
      @(posedge ref_clk_in);
    end
  endtask

  // ----
  // Tests
  // ----
  initial begin
    miscompares = 0;
    compares = 0;
    cycles = 0;
    req = '0;
    sys_rst_in = 1'b1;
    cpu_irq_mask_in = 1'b1;
    repeat (2) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge ref_clk_in);
    rdr(8'h60);
    chk("counter high", 16'(rd), 16'h00ff);
    rdr(8'h48);
    chk("control", 16'(rd & 8'he5), 16'h0000);
    rdr(8'h40);
    chk("unmapped error", 16'(err), 16'h0001);
    apb(1'b1, 8'h58, 8'h12);
    apb(1'b1, 8'h5c, 8'h34);
    apb(1'b1, 8'h58, 8'h56);
    rdr(8'h58);
    chk("compare high", 16'(rd), 16'h0056);
    rdr(8'h5c);
    chk("compare low", 16'(rd), 16'h0034);
    $display("test reset and map done");

    cpu_irq_mask_in <= 1'b0;
    apb(1'b1, 8'h48, 8'h45);
    read_cnt();
    tgt = cnt + 16'h0020;
    apb(1'b1, 8'h5c, tgt[7:0]);
    apb(1'b1, 8'h58, tgt[15:8]);
    wait_pin(1'b1, 300);
    chk("pin held by high write", 16'(pin_out), 16'h0000);
    read_cnt();
    tgt = cnt + 16'h0010;
    apb(1'b1, 8'h58, tgt[15:8]);
    apb(1'b1, 8'h5c, tgt[7:0]);
    wait_pin(1'b1, 200);
    chk("pin after match", 16'(pin_out), 16'h0001);
    @(posedge ref_clk_in);
    chk("compare irq", 16'(irq), 16'h0001);
    cpu_irq_mask_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    chk("masked irq", 16'(irq), 16'h0000);
    cpu_irq_mask_in <= 1'b0;
    apb(1'b1, 8'h48, 8'h44);
    read_cnt();
    tgt = cnt + 16'h0010;
    apb(1'b1, 8'h58, tgt[15:8]);
    apb(1'b1, 8'h5c, tgt[7:0]);
    wait_pin(1'b0, 200);
    chk("low level with flag set", 16'(pin_out), 16'h0000);
    rdr(8'h4c);
    chk("compare flag", 16'(rd[6]), 16'h0001);
    rdr(8'h5c);
    rdr(8'h4c);
    chk("compare flag cleared", 16'(rd[6]), 16'h0000);
    $display("test compare done");

    apb(1'b1, 8'h48, 8'h86);
    read_cnt();
    cap0 = cnt;
    i_tcc_pin_src.drive_cap(1'b1);
    read_cap();
    chk("capture offset", 16'((cap - cap0) inside {[16'h0001:16'h0004]}), 16'h0001);
    chk("capture irq", 16'(irq), 16'h0001);
    apb(1'b1, 8'h48, 8'h04);
    rdr(8'h50);
    i_tcc_pin_src.drive_cap(1'b0);
    cap0 = cap;
    read_cap();
    chk("capture blocked", cap, cap0);
    i_tcc_pin_src.drive_cap(1'b1);
    read_cap();
    chk("rising ignored", cap, cap0);
    i_tcc_pin_src.drive_cap(1'b0);
    read_cap();
    chk("capture overwritten", 16'(cap != cap0), 16'h0001);
    rdr(8'h4c);
    rdr(8'h54);
    rdr(8'h4c);
    chk("capture flag cleared", 16'(rd[7]), 16'h0000);
    $display("test capture done");
    close_out();
  end
endmodule

`default_nettype wire
